// ===== logic/hbc_regs.svh
// hbc_regs.svh: register map, field positions, reset values and timing counts of the bridge controller
// assumes a 250 MHz core clock and 32-bit APB data with word-aligned registers
`ifndef HBC_REGS_SVH
`define HBC_REGS_SVH

// register byte offsets
`define HBC_OFS_CTRL        12'h000
`define HBC_OFS_PERIOD      12'h004
`define HBC_OFS_DUTY        12'h008
`define HBC_OFS_STATUS      12'h00C
`define HBC_OFS_MASK        12'h010
`define HBC_OFS_PINS        12'h014

// control register fields
`define HBC_CTRL_MODE_LSB   0
`define HBC_CTRL_MODE_MSB   1
`define HBC_CTRL_DIR_BIT    2
`define HBC_CTRL_WSTOP_BIT  3
`define HBC_CTRL_RESET      4'h0

// period and duty widths and reset values
`define HBC_CNT_W           16
`define HBC_PERIOD_RESET    16'h03E8
`define HBC_DUTY_RESET      16'h0000

// status and mask bits (status clears by writing one)
`define HBC_EV_W            3
`define HBC_EV_WARN_SET     0
`define HBC_EV_WARN_CLR     1
`define HBC_EV_SETTLED      2

// pins readback fields
`define HBC_PIN_DIR_BIT     0
`define HBC_PIN_BRAKE_BIT   1
`define HBC_PIN_PULSE_BIT   2
`define HBC_PIN_WARN_BIT    3
`define HBC_PIN_BUSY_BIT    4
`define HBC_PIN_SW_LSB      5

// timing
`define HBC_CLK_PERIOD_PS   4000
`define HBC_MIN_PULSE_NS    1000
`define HBC_MIN_GAP_NS      500
`define HBC_MIN_PULSE_CYC   ((`HBC_MIN_PULSE_NS * 1000 + `HBC_CLK_PERIOD_PS - 1) / `HBC_CLK_PERIOD_PS)
`define HBC_MIN_GAP_CYC     ((`HBC_MIN_GAP_NS * 1000 + `HBC_CLK_PERIOD_PS - 1) / `HBC_CLK_PERIOD_PS)
`define HBC_HOLD_W          9

`endif

// ===== logic/hbc_pkg.sv
// hbc_pkg: types shared by the bridge controller files
// assumes hbc_regs.svh for numeric constants
package hbc_pkg;

  // drive formats selected by software
  typedef enum logic [1:0] {
    HBC_MODE_OFF,
    HBC_MODE_SIGN_MAG,
    HBC_MODE_ANTI_PHASE,
    HBC_MODE_BRAKE
  } hbc_mode_e;

  // pin sequencer states
  typedef enum logic [0:0] {
    HBC_SEQ_READY,
    HBC_SEQ_HOLD
  } hbc_seq_e;

  // decoded switch set: source 1, sink 1, source 2, sink 2
  typedef logic [3:0] hbc_sw_t;

endpackage

// ===== logic/hbc_pwm.sv
// hbc_pwm: free-running duty-cycle generator, level high for duty of every period cycles
// assumes period and duty are stable register values; a period of zero yields a constant low
`timescale 1ns/1ps
`include "hbc_regs.svh"

module hbc_pwm
  import hbc_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // settings
  input  wire logic                  run,
  input  wire logic [`HBC_CNT_W-1:0] period,
  input  wire logic [`HBC_CNT_W-1:0] duty,
  // generated level
  output logic                       level
);

  logic [`HBC_CNT_W-1:0] count;

  // period counter, restarts whenever generation stops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!run || count >= period - `HBC_CNT_W'(1)) begin
      count <= '0;
    end else begin
      count <= count + `HBC_CNT_W'(1);
    end
  end

  // registered level so the pin path never sees a comparator glitch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else begin
      level <= run && (period != '0) && (count < duty);
    end
  end

endmodule

// ===== logic/hbc_ctrl.sv
// hbc_ctrl: motion controller that drives an H-bridge through its direction, brake and pulse pins
// assumes APB from software, pins synchronous to core_clk, and a pulled-up open-collector warning line
//
// Design decisions made here: the register offsets and the APB register port.

`timescale 1ns/1ps
`include "hbc_regs.svh"

// Behaviour
// R01: with brake low, pulse high selects source 1 and sink 2 for direction high, sink 1 and source 2 for low, and pulse low selects both sources.
// R02: braking is commanded by holding brake and pulse high, direction choosing both sources or both sinks.
// R03: brake high with pulse low turns all four switches off whatever the direction.
// R04: the bridge pulls its warning output low at 145 degrees while its outputs keep running.
// R05: the bridge shuts its outputs off only at 170 degrees, above the warning point.
// R06: each level on direction, brake and pulse is held for at least 1 us.
// R07: no two of the three pins change together, and at least 1 us separates changes on different pins.
// R08: at least 500 ns is left between the end of one pin change and the start of the next.
// R09: locked anti-phase drive puts the duty signal on direction and holds pulse high, 50% meaning no drive.
// R10: sign/magnitude drive puts the sign on direction and the duty signal on pulse, constant low meaning no drive.
// R11: the warning output is open collector so several bridges can share one interrupt line.
// R12: during controller reset brake is high and pulse low so all switches stay off.
module hbc_ctrl
  import hbc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // bridge pins
  output logic             dir_pin,
  output logic             brake_pin,
  output logic             pulse_pin,
  input  wire logic        warn_n,
  // interrupt
  output logic             irq
);

  // one spacing covers both the minimum level time and the conservative gap between changes
  localparam logic [`HBC_HOLD_W-1:0] SEP_CYC =
    `HBC_HOLD_W'((`HBC_MIN_PULSE_CYC > `HBC_MIN_GAP_CYC) ? `HBC_MIN_PULSE_CYC : `HBC_MIN_GAP_CYC);

  // software registers
  hbc_mode_e             mode;
  logic                  dir_cmd;
  logic                  warn_stop;
  logic [`HBC_CNT_W-1:0] period;
  logic [`HBC_CNT_W-1:0] duty;
  logic [`HBC_EV_W-1:0]  status;
  logic [`HBC_EV_W-1:0]  mask;

  // pin sequencing
  hbc_seq_e              seq_state;
  logic [`HBC_HOLD_W-1:0] hold_cnt;
  logic                  gen_level;
  logic                  warn_prev;
  logic                  busy_prev;
  logic                  next_dir;
  logic                  next_brake;
  logic                  next_pulse;
  hbc_mode_e             eff_mode;
  logic                  busy;
  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_ok;
  logic [`HBC_EV_W-1:0]  ev;
  // read path
  logic [31:0]           rd_word;

  // switches that the bridge turns on for a given pin set: {snk2, src2, snk1, src1}
  function automatic hbc_sw_t hbc_decode(input logic d, input logic b, input logic p);
    hbc_sw_t s;
    s = 4'h0;
    if (!b && p) begin
      // R01: forward or reverse drive
      s = d ? 4'h9 : 4'h6;
    end else if (!b) begin
      // R01: both sources on
      s = 4'h5;
    end else if (p) begin
      // R02: brake through sources or sinks
      s = d ? 4'h5 : 4'hA;
    end else begin
      // R03: all switches off
      s = 4'h0;
    end
    return s;
  endfunction

  // apb decode, zero wait states; writes land at the access edge,
  // while a read is captured at the end of its setup cycle so the access cycle shows a registered word
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `HBC_OFS_CTRL) || (paddr == `HBC_OFS_PERIOD) || (paddr == `HBC_OFS_DUTY) ||
                   (paddr == `HBC_OFS_STATUS) || (paddr == `HBC_OFS_MASK) || (paddr == `HBC_OFS_PINS);
  assign pslverr = psel && penable && !addr_ok;

  // control register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode      <= HBC_MODE_OFF;
      dir_cmd   <= 1'b0;
      warn_stop <= 1'b0;
    end else if (wr_en && paddr == `HBC_OFS_CTRL) begin
      mode      <= hbc_mode_e'(pwdata[`HBC_CTRL_MODE_MSB:`HBC_CTRL_MODE_LSB]);
      dir_cmd   <= pwdata[`HBC_CTRL_DIR_BIT];
      warn_stop <= pwdata[`HBC_CTRL_WSTOP_BIT];
    end
  end

  // period and duty of the generator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period <= `HBC_PERIOD_RESET;
      duty   <= `HBC_DUTY_RESET;
    end else if (wr_en) begin
      if (paddr == `HBC_OFS_PERIOD) begin
        period <= pwdata[`HBC_CNT_W-1:0];
      end
      if (paddr == `HBC_OFS_DUTY) begin
        duty <= pwdata[`HBC_CNT_W-1:0];
      end
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask <= '0;
    end else if (wr_en && paddr == `HBC_OFS_MASK) begin
      mask <= pwdata[`HBC_EV_W-1:0];
    end
  end

  // word of the addressed register, zero for holes in the map
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        `HBC_OFS_CTRL: begin
          rd_word[`HBC_CTRL_MODE_MSB:`HBC_CTRL_MODE_LSB] = mode;
          rd_word[`HBC_CTRL_DIR_BIT]                     = dir_cmd;
          rd_word[`HBC_CTRL_WSTOP_BIT]                   = warn_stop;
        end
        `HBC_OFS_PERIOD: rd_word[`HBC_CNT_W-1:0] = period;
        `HBC_OFS_DUTY:   rd_word[`HBC_CNT_W-1:0] = duty;
        `HBC_OFS_STATUS: rd_word[`HBC_EV_W-1:0]  = status;
        `HBC_OFS_MASK:   rd_word[`HBC_EV_W-1:0]  = mask;
        `HBC_OFS_PINS: begin
          rd_word[`HBC_PIN_DIR_BIT]                      = dir_pin;
          rd_word[`HBC_PIN_BRAKE_BIT]                    = brake_pin;
          rd_word[`HBC_PIN_PULSE_BIT]                    = pulse_pin;
          rd_word[`HBC_PIN_WARN_BIT]                     = !warn_n;
          rd_word[`HBC_PIN_BUSY_BIT]                     = busy;
          rd_word[`HBC_PIN_SW_LSB+3:`HBC_PIN_SW_LSB]     = hbc_decode(dir_pin, brake_pin, pulse_pin);
        end
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // registered read word: taken at the end of the setup cycle and standing through the access cycle,
  // zero at every other time; a status event in the access cycle itself shows on the next read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_word;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // a warning may force the safe off state; the bridge itself keeps running until its own shutdown,
  // so without warn_stop software alone decides how to react to an overheating bridge
  assign eff_mode = (warn_stop && !warn_n) ? HBC_MODE_OFF : mode;

  // duty generator; stops when its output is not used
  hbc_pwm u_pwm (
    .core_clk (core_clk),
    .rst      (rst),
    .run      ((eff_mode == HBC_MODE_SIGN_MAG) || (eff_mode == HBC_MODE_ANTI_PHASE)),
    .period   (period),
    .duty     (duty),
    .level    (gen_level)
  );

  // target pin levels for the selected drive format
  always_comb begin
    next_dir   = dir_cmd;
    next_brake = 1'b1;
    next_pulse = 1'b0;
    unique case (eff_mode)
      HBC_MODE_OFF: begin
        // R03: brake high, pulse low, all switches off
        next_brake = 1'b1;
        next_pulse = 1'b0;
      end
      HBC_MODE_SIGN_MAG: begin
        // R10: sign on direction, magnitude on pulse
        next_brake = 1'b0;
        next_pulse = gen_level;
      end
      HBC_MODE_ANTI_PHASE: begin
        // R09: duty on direction, pulse held high
        next_dir   = gen_level;
        next_brake = 1'b0;
        next_pulse = 1'b1;
      end
      HBC_MODE_BRAKE: begin
        // R02: brake and pulse both high
        next_brake = 1'b1;
        next_pulse = 1'b1;
      end
    endcase
  end

  // busy while a hold runs or while any pin still differs from its target
  assign busy = (seq_state == HBC_SEQ_HOLD) || (next_dir != dir_pin) ||
                (next_brake != brake_pin) || (next_pulse != pulse_pin);

  // one pin change at a time, then a full hold; brake rises first so a mode change passes safe states,
  // pulses shorter than the hold are stretched or skipped rather than sent too short
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // R12: switches off during reset
      dir_pin   <= 1'b0;
      brake_pin <= 1'b1;
      pulse_pin <= 1'b0;
      seq_state <= HBC_SEQ_READY;
      hold_cnt  <= '0;
    end else begin
      unique case (seq_state)
        HBC_SEQ_READY: begin
          // R07: only one pin changes per step
          if (next_brake && !brake_pin) begin
            brake_pin <= 1'b1;
            seq_state <= HBC_SEQ_HOLD;
          end else if (next_pulse != pulse_pin) begin
            pulse_pin <= next_pulse;
            seq_state <= HBC_SEQ_HOLD;
          end else if (next_dir != dir_pin) begin
            dir_pin   <= next_dir;
            seq_state <= HBC_SEQ_HOLD;
          end else if (next_brake != brake_pin) begin
            brake_pin <= next_brake;
            seq_state <= HBC_SEQ_HOLD;
          end
          hold_cnt <= SEP_CYC - `HBC_HOLD_W'(1);
        end
        HBC_SEQ_HOLD: begin
          // R06: level held a full microsecond
          // R08: spacing covers the conservative gap too
          if (hold_cnt == '0) begin
            seq_state <= HBC_SEQ_READY;
          end else begin
            hold_cnt <= hold_cnt - `HBC_HOLD_W'(1);
          end
        end
      endcase
    end
  end

  // edge history for events
  // history resets to the idle levels so leaving reset raises no false warning or settled event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      warn_prev <= 1'b0;
      busy_prev <= 1'b0;
    end else begin
      warn_prev <= !warn_n;
      busy_prev <= busy;
    end
  end

  // R11: the shared open-collector line is read as a plain active-low input
  always_comb begin
    ev                   = '0;
    ev[`HBC_EV_WARN_SET] = !warn_n && !warn_prev;
    ev[`HBC_EV_WARN_CLR] = warn_n && warn_prev;
    ev[`HBC_EV_SETTLED]  = !busy && busy_prev;
  end

  // sticky status, write one to clear; a new event in the clearing cycle wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else if (wr_en && paddr == `HBC_OFS_STATUS) begin
      status <= (status & ~pwdata[`HBC_EV_W-1:0]) | ev;
    end else begin
      status <= status | ev;
    end
  end

  // level interrupt
  assign irq = |(status & mask);

endmodule

// ===== sim/hbc_ctrl_sva.sv
// hbc_ctrl_sva: port checks of the bridge controller
// assumes it is bound onto hbc_ctrl and sees only its ports
`timescale 1ns/1ps
`include "hbc_regs.svh"
module hbc_ctrl_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // bridge pins
  input wire logic        dir_pin,
  input wire logic        brake_pin,
  input wire logic        pulse_pin
);
  logic [2:0] pins;
  logic [2:0] prev;
  logic [7:0] gap;
  logic       acc;
  logic       mapped;

  // access phase and the six word offsets
  assign pins   = {dir_pin, brake_pin, pulse_pin};
  assign acc    = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `HBC_OFS_PINS);

  // cycles since a pin last moved, saturating so long idle spans never wrap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev <= 3'h2;
      gap  <= 8'hFF;
    end else begin
      prev <= pins;
      gap  <= (pins != prev) ? 8'h00 : ((gap == 8'hFF) ? gap : gap + 8'h01);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_lone_pin_move: assert property (
    $countones(pins ^ prev) <= 1) else $error("two bridge pins moved together");
  a_pin_gap_min: assert property (
    pins != prev |-> gap >= 8'hFA) else $error("pin moved before the hold ran out");
  a_pin_short_hold: assert property (
    pins != prev |=> (pins == prev) [*8]) else $error("pin level too short");
  a_reset_safe: assert property (
    $fell(rst) |-> brake_pin && !pulse_pin) else $error("switches not off at reset release");
  a_ready_always: assert property (
    pready) else $error("pready low");
  a_err_unmapped: assert property (
    acc |-> pslverr == !mapped) else $error("slave error does not match the address");
  a_rdata_unmapped: assert property (
    acc && !mapped |-> prdata == 32'h0) else $error("unmapped read data not zero");
  a_rdata_idle: assert property (
    !acc |-> prdata == 32'h0) else $error("read data not zero outside access");
endmodule

bind hbc_ctrl hbc_ctrl_sva chk_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dir_pin(dir_pin),
  .brake_pin(brake_pin), .pulse_pin(pulse_pin));

// ===== sim/hbc_bridge_model.sv
// hbc_bridge_model: behavioural H-bridge answering the three control pins
// assumes the bench sets temp in degrees and pulls the warning line up
`timescale 1ns/1ps
module hbc_bridge_model
  import hbc_pkg::*;
(
  // control pins
  input  wire logic dir_pin,
  input  wire logic brake_pin,
  input  wire logic pulse_pin,
  // die temperature
  input  var  int   temp,
  // switches {snk2,src2,snk1,src1} and warning pull-down
  output hbc_sw_t   sw,
  output logic      warn_oe
);
  // open collector only sinks the shared line, outputs keep running
  assign warn_oe = temp >= 145;

  // decode; shutdown wins over every pin state
  always_comb begin
    if (temp >= 170) sw = 4'h0;
    else if (!pulse_pin) sw = brake_pin ? 4'h0 : 4'h5;
    else if (brake_pin) sw = dir_pin ? 4'h5 : 4'hA;
    else sw = dir_pin ? 4'h9 : 4'h6;
  end
endmodule

// ===== sim/tb.sv
// tb: self-checking bench of the bridge controller with a behavioural bridge
// assumes hbc_ctrl, the bridge model and the bound checker are compiled first
`timescale 1ns/1ps
`include "hbc_regs.svh"
module tb
  import hbc_pkg::*;
;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        dir_pin, brake_pin, pulse_pin, warn_n, irq, warn_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  hbc_sw_t     sw;
  int          temp, errors, compares;

  hbc_ctrl dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dir_pin(dir_pin), .brake_pin(brake_pin), .pulse_pin(pulse_pin), .warn_n(warn_n), .irq(irq));
  hbc_bridge_model bridge_u (.dir_pin(dir_pin), .brake_pin(brake_pin), .pulse_pin(pulse_pin),
    .temp(temp), .sw(sw), .warn_oe(warn_oe));
  assign warn_n = warn_oe ? 1'b0 : 1'b1;

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe = 1'b0);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  // reads until the masked field matches; the watchdog bounds the wait
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    q = ~x;
    while ((q & m) !== x) apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic go(input logic [31:0] c, input logic [31:0] p, input logic [3:0] s);
    wr(`HBC_OFS_CTRL, c);
    poll(`HBC_OFS_PINS, 32'h1F, p);
    chk({28'h0, sw}, {28'h0, s});
  endtask

  // irq is looked at one edge later so a write's own edge has landed
  task automatic irq_is(input logic x);
    @(posedge core_clk);
    chk({31'h0, irq}, {31'h0, x});
  endtask

  task automatic t_reset();
    rd(`HBC_OFS_CTRL, 32'h0, 1'b0);
    rd(`HBC_OFS_PERIOD, 32'h3E8, 1'b0);
    rd(`HBC_OFS_DUTY, 32'h0, 1'b0);
    rd(`HBC_OFS_STATUS, 32'h0, 1'b0);
    rd(`HBC_OFS_MASK, 32'h0, 1'b0);
    rd(`HBC_OFS_PINS, 32'h2, 1'b0);
    chk({28'h0, sw}, 32'h0);
  endtask

  task automatic t_bus();
    rd(12'h018, 32'h0, 1'b1);
    wr(12'h800, 32'h3, 1'b1);
    wr(`HBC_OFS_PINS, 32'h1FF);
    rd(`HBC_OFS_PINS, 32'h2, 1'b0);
    rd(`HBC_OFS_CTRL, 32'h0, 1'b0);
    wr(`HBC_OFS_PERIOD, 32'hFFFF_1234);
    rd(`HBC_OFS_PERIOD, 32'h1234, 1'b0);
    wr(`HBC_OFS_PERIOD, 32'h3E8);
  endtask

  task automatic t_modes();
    go(32'h7, 32'h7, 4'h5);
    go(32'h3, 32'h6, 4'hA);
    go(32'h0, 32'h2, 4'h0);
    go(32'h5, 32'h1, 4'h5);
    wr(`HBC_OFS_DUTY, 32'hFFFF);
    go(32'h5, 32'h5, 4'h9);
    go(32'h1, 32'h4, 4'h6);
  endtask

  task automatic t_anti();
    int   n;
    logic d;
    n = 0;
    wr(`HBC_OFS_DUTY, 32'h1F4);
    wr(`HBC_OFS_CTRL, 32'h2);
    poll(`HBC_OFS_PINS, 32'h6, 32'h4);
    d = dir_pin;
    repeat (3000) begin
      @(posedge core_clk);
      if (dir_pin !== d) n++;
      d = dir_pin;
      if (brake_pin !== 1'b0 || pulse_pin !== 1'b1) n = -99;
    end
    chk({31'h0, n >= 4}, 32'h1);
  endtask

  task automatic t_thermal();
    go(32'h7, 32'h7, 4'h5);
    wr(`HBC_OFS_STATUS, 32'h7);
    temp <= 175;
    poll(`HBC_OFS_STATUS, 32'h1, 32'h1);
    chk({28'h0, sw}, 32'h0);
    temp <= 150;
    rd(`HBC_OFS_PINS, 32'hAF, 1'b0);
    chk({28'h0, sw}, 32'h5);
    irq_is(1'b0);
    wr(`HBC_OFS_MASK, 32'h1);
    irq_is(1'b1);
    wr(`HBC_OFS_STATUS, 32'h1);
    irq_is(1'b0);
    temp <= 100;
    poll(`HBC_OFS_STATUS, 32'h2, 32'h2);
    wr(`HBC_OFS_MASK, 32'h4);
    wr(`HBC_OFS_STATUS, 32'h7);
    go(32'hF, 32'h7, 4'h5);
    temp <= 150;
    poll(`HBC_OFS_PINS, 32'h1F, 32'hB);
    irq_is(1'b1);
    wr(`HBC_OFS_STATUS, 32'h7);
    irq_is(1'b0);
    temp <= 25;
    poll(`HBC_OFS_PINS, 32'h1F, 32'h7);
  endtask

  task automatic summarize();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // main sequence, inputs held quiet through reset
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    temp = 25;
    errors = 0;
    compares = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_bus();
    t_modes();
    t_anti();
    t_thermal();
    summarize();
  end

  // a hang in any poll ends here instead of running forever
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule
